// ---- tb.sv ----
// Testbench for reset routing, suspend, resume and wake-up control
`timescale 1ns/100ps
`include "usb_rsw_consts.svh"

module tb;
    localparam int IDLE_N = 20;
    localparam int KEXT_N = 10;

    logic       clk_in = 1'b0;
    logic       srst_in = 1'b1;
    logic       master_reset_n_in = 1'b1;
    logic [7:0] wake_port_in;
    logic       external_irq_n_in;
    logic [2:0] addr_in = 3'h0;
    logic [7:0] wdata_in = 8'h00;
    logic       wr_in = 1'b0;
    logic       rd_in = 1'b0;
    logic [7:0] rdata_out;
    logic       bus_reset_det, line_idle, reset_out, core_reset_out, sie_ubm_reset_out;
    logic       codec_reset_n_out, int0_out, usb_irq_out, clocks_run_out, drive_k_out;
    logic       pullup_connect_out, boot_rom_shadow_out, saw_rst, saw_sie;
    int         miscompares = 0;
    int         n_compared = 0;
    int         n;

    // 25 MHz clock
    always #20 clk_in = ~clk_in;

    usb_reset_suspend_wakeup #(.IDLE_CYCLES(IDLE_N), .K_EXT_CYCLES(KEXT_N))
        u_usb_reset_suspend_wakeup (
        .clk_in(clk_in), .srst_in(srst_in), .master_reset_n_in(master_reset_n_in),
        .bus_reset_det_in(bus_reset_det), .line_idle_in(line_idle), .wake_port_in(wake_port_in),
        .external_irq_n_in(external_irq_n_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .reset_out(reset_out),
        .core_reset_out(core_reset_out), .sie_ubm_reset_out(sie_ubm_reset_out),
        .codec_reset_n_out(codec_reset_n_out), .int0_out(int0_out), .usb_irq_out(usb_irq_out),
        .clocks_run_out(clocks_run_out), .drive_k_out(drive_k_out),
        .pullup_connect_out(pullup_connect_out), .boot_rom_shadow_out(boot_rom_shadow_out));

    usb_host_model u_usb_host_model (.clk_in(clk_in), .drive_k_in(drive_k_out),
        .bus_reset_det_out(bus_reset_det), .line_idle_out(line_idle));

    // ==========================================
    // Compare and report helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp, input string what);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic chk1(input logic got, input logic exp, input string what);
        check({7'h00, got}, {7'h00, exp}, what);
    endtask

    task automatic print_verdict();
        $display("Compared %0d, mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // ==========================================
    // Register port and event helpers
    // Wake port and irq pin levels, changed together
    task automatic set_pins(input logic [7:0] p, input logic x);
        wake_port_in <= p;
        external_irq_n_in <= x;
    endtask

    task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask

    task automatic reg_rd(input logic [2:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1 check(rdata_out, exp, what);
    endtask

    // Bounded wait for a level, counted in cycles
    task automatic wait_lvl(ref logic s, input logic lvl, input int lim, output int cnt);
        cnt = 0;
        while (s !== lvl && cnt < lim) begin
            @(posedge clk_in);
            #1;
            cnt++;
        end
        chk1(s, lvl, "awaited level");
    endtask

    // Bus reset, watching reset_out and sie_ubm_reset_out for three cycles
    task automatic bus_rst();
        saw_rst = 1'b0;
        saw_sie = 1'b0;
        u_usb_host_model.bus_reset();
        repeat (3) begin
            #1;
            saw_rst = saw_rst | reset_out;
            saw_sie = saw_sie | sie_ubm_reset_out;
            @(posedge clk_in);
        end
        #1;
    endtask

    // Idle until flagged, clear the flag, then stop the clocks
    task automatic enter_suspend();
        int c;
        u_usb_host_model.set_idle(1'b1);
        wait_lvl(usb_irq_out, 1'b1, 60, c);
        chk1(c >= IDLE_N, 1'b1, "idle span");
        reg_rd(`ADDR_IRQ_VEC, `VEC_SUSP, "suspend vector");
        reg_wr(`ADDR_IRQ_VEC, 8'h5a);
        reg_rd(`ADDR_USB_STA, 8'h00, "suspend flag cleared");
        reg_wr(`ADDR_PWR_CTL, 8'h01);
        chk1(clocks_run_out, 1'b0, "clocks stopped");
    endtask

    // ==========================================
    // Test sequence
    initial begin
        set_pins(8'hff, 1'b1);
        repeat (4) @(posedge clk_in);
        srst_in <= 1'b0;
        repeat (4) @(posedge clk_in);
        reg_rd(`ADDR_WAKE_MSK, `WAKE_MSK_RST, "wake mask reset");
        reg_rd(`ADDR_USB_CTL, 8'h00, "control reset");
        chk1(codec_reset_n_out, 1'b0, "codec reset after reset");
        reg_wr(`ADDR_CODEC_CTL, 8'h01);
        chk1(codec_reset_n_out, 1'b1, "codec released");
        reg_wr(`ADDR_USB_MSK, 8'h07);
        bus_rst();
        chk1(int0_out, 1'b1, "bus reset interrupt");
        chk1(saw_rst, 1'b0, "no reset in irq mode");
        reg_rd(`ADDR_USB_STA, 8'h01, "bus reset flag");
        reg_rd(`ADDR_IRQ_VEC, `VEC_BUS_RST, "bus reset vector");
        reg_wr(`ADDR_IRQ_VEC, 8'h00);
        reg_rd(`ADDR_USB_STA, 8'h00, "bus reset flag cleared");
        reg_wr(`ADDR_USB_MSK, 8'h06);
        bus_rst();
        chk1(saw_sie, 1'b1, "local reset");
        chk1(saw_rst | int0_out, 1'b0, "nothing else reset");
        reg_rd(`ADDR_USB_STA, 8'h01, "flag with mask clear");
        reg_wr(`ADDR_IRQ_VEC, 8'h00);
        reg_wr(`ADDR_USB_CTL, 8'h0d);
        bus_rst();
        chk1(saw_rst, 1'b1, "global reset output");
        reg_rd(`ADDR_USB_STA, 8'h00, "flag cleared by global");
        reg_rd(`ADDR_USB_CTL, 8'h0d, "kept control bits");
        reg_rd(`ADDR_USB_MSK, 8'h00, "mask reset by global");
        chk1(pullup_connect_out & boot_rom_shadow_out & codec_reset_n_out, 1'b1, "kept");
        reg_wr(`ADDR_USB_CTL, 8'h0c);
        reg_wr(`ADDR_USB_MSK, 8'h07);
        reg_wr(`ADDR_GLOBAL_CTL, 8'h01);
        // Idle broken by traffic must restart the count
        u_usb_host_model.set_idle(1'b1);
        repeat (IDLE_N - 5) @(posedge clk_in);
        u_usb_host_model.set_idle(1'b0);
        repeat (3) @(posedge clk_in);
        u_usb_host_model.set_idle(1'b1);
        repeat (IDLE_N - 8) @(posedge clk_in);
        #1 chk1(usb_irq_out, 1'b0, "idle restarted");
        u_usb_host_model.set_idle(1'b0);
        repeat (4) @(posedge clk_in);
        // Suspend then resume by bus traffic
        enter_suspend();
        u_usb_host_model.set_idle(1'b0);
        wait_lvl(clocks_run_out, 1'b1, 8, n);
        reg_rd(`ADDR_PWR_CTL, 8'h00, "idle bit cleared");
        reg_rd(`ADDR_IRQ_VEC, `VEC_RES, "resume vector");
        reg_wr(`ADDR_IRQ_VEC, 8'h00);
        reg_rd(`ADDR_USB_STA, 8'h00, "resume flag cleared");
        // Wake by port bit 0, then by the irq pin as bit 2
        for (int i = 0; i < 2; i++) begin
            reg_wr(`ADDR_WAKE_MSK, (i == 0) ? 8'hfe : 8'hfb);
            enter_suspend();
            @(posedge clk_in);
            set_pins(8'hff, 1'b0);
            if (i == 0) begin
                repeat (6) @(posedge clk_in);
                set_pins(8'hfe, 1'b0);
                #1 chk1(clocks_run_out, 1'b0, "masked irq pin ignored");
            end
            wait_lvl(clocks_run_out, 1'b1, 8, n);
            u_usb_host_model.set_idle(1'b0);
            reg_rd(`ADDR_IRQ_VEC, `VEC_WAKE, "wake vector");
            chk1(int0_out, 1'b1, "wake interrupt");
            reg_wr(`ADDR_IRQ_VEC, 8'h00);
            chk1(int0_out, 1'b0, "wake interrupt cleared");
            set_pins(8'hff, 1'b1);
        end
        // Remote wake pulse then K extension
        reg_wr(`ADDR_USB_CTL, 8'h0e);
        chk1(drive_k_out, 1'b1, "K driven");
        repeat (5) @(posedge clk_in);
        reg_wr(`ADDR_USB_CTL, 8'h0c);
        wait_lvl(drive_k_out, 1'b0, 40, n);
        chk1(n >= KEXT_N - 1 && n <= KEXT_N + 1, 1'b1, "K extension");
        // Master reset pin
        @(posedge clk_in);
        master_reset_n_in <= 1'b0;
        wait_lvl(reset_out, 1'b1, 5, n);
        chk1(core_reset_out & sie_ubm_reset_out, 1'b1, "core reset");
        @(posedge clk_in);
        master_reset_n_in <= 1'b1;
        wait_lvl(reset_out, 1'b0, 8, n);
        reg_rd(`ADDR_USB_MSK, 8'h00, "mask reset by pin");
        chk1(codec_reset_n_out, 1'b1, "codec independent");
        print_verdict();
    end

    // Watchdog against a hang
    initial begin
        #(40 * 20000);
        miscompares++;
        print_verdict();
    end
endmodule // tb

// ---- usb_host_model.sv ----
// Behavioural upstream host: bus reset pulses and line idle state
`timescale 1ns/100ps

module usb_host_model (
    input  wire logic clk_in,
    input  wire logic drive_k_in,
    output logic      bus_reset_det_out,
    output logic      line_idle_out
);
    logic idle_req;

    // ==========================================
    // Line state
    // Device K drive makes the line non-idle, as on the real wire
    assign line_idle_out = idle_req & ~drive_k_in;

    // Traffic on the line until a test asks for idle J
    initial begin
        bus_reset_det_out = 1'b0;
        idle_req = 1'b0;
    end

    // One-cycle detected bus reset, changed just after an edge
    task automatic bus_reset();
        @(posedge clk_in);
        bus_reset_det_out <= 1'b1;
        @(posedge clk_in);
        bus_reset_det_out <= 1'b0;
    endtask

    // Idle J when level is 1, traffic otherwise
    task automatic set_idle(input logic level);
        @(posedge clk_in);
        idle_req <= level;
    endtask
endmodule // usb_host_model

// ---- usb_reset_suspend_wakeup.sv ----
// Reset routing, suspend detection, resume and remote wake-up control
`timescale 1ns/100ps
`include "usb_rsw_consts.svh"

module usb_reset_suspend_wakeup #(
    parameter int IDLE_CYCLES = (`IDLE_TIME_US * `CLK_FREQ_KHZ) / 1000,
    parameter int K_EXT_CYCLES = (`K_EXT_TIME_US * `CLK_FREQ_KHZ + 999) / 1000,
    parameter int CNT_W = 20,
    parameter int PORT_W = 8
) (
    input  wire logic              clk_in,
    input  wire logic              srst_in,
    input  wire logic              master_reset_n_in,
    input  wire logic              bus_reset_det_in,
    input  wire logic              line_idle_in,
    input  wire logic [PORT_W-1:0] wake_port_in,
    input  wire logic              external_irq_n_in,
    input  wire logic [2:0]        addr_in,
    input  wire logic [7:0]        wdata_in,
    input  wire logic              wr_in,
    input  wire logic              rd_in,
    output logic      [7:0]        rdata_out,
    output logic                   reset_out,
    output logic                   core_reset_out,
    output logic                   sie_ubm_reset_out,
    output logic                   codec_reset_n_out,
    output logic                   int0_out,
    output logic                   usb_irq_out,
    output logic                   clocks_run_out,
    output logic                   drive_k_out,
    output logic                   pullup_connect_out,
    output logic                   boot_rom_shadow_out
);
    import usb_rsw_pkg::*;

    // ==========================================
    // Elaboration checks
    if (IDLE_CYCLES < 2 || IDLE_CYCLES >= (1 << CNT_W)) begin : g_chk_idle
        $error("idle count does not fit the counter");
    end
    if (K_EXT_CYCLES < 1 || K_EXT_CYCLES >= (1 << CNT_W)) begin : g_chk_k
        $error("k extension count does not fit the counter");
    end
    if (PORT_W <= `WAKE_XIRQ_BIT || PORT_W > 8) begin : g_chk_port
        $error("wake port width unsupported");
    end

    localparam logic [CNT_W-1:0] IDLE_LAST = CNT_W'(IDLE_CYCLES - 1);
    localparam logic [CNT_W-1:0] K_LOAD    = CNT_W'(K_EXT_CYCLES);

    // ==========================================
    // Pin synchronisers
    logic              mrst_n_meta;
    logic              mrst_n_sync;
    logic              idle_meta;
    logic              idle_sync;
    logic              xirq_meta;
    logic              xirq_sync;
    logic [PORT_W-1:0] port_meta;
    logic [PORT_W-1:0] port_sync;

    // Two flops per pin
    always_ff @(posedge clk_in) begin
        mrst_n_meta <= master_reset_n_in;
        mrst_n_sync <= mrst_n_meta;
        idle_meta   <= line_idle_in;
        idle_sync   <= idle_meta;
        xirq_meta   <= external_irq_n_in;
        xirq_sync   <= xirq_meta;
        port_meta   <= wake_port_in;
        port_sync   <= port_meta;
    end

    // ==========================================
    // Reset routing
    logic hard_rst;
    logic usb_glob_rst;
    logic glob_rst;
    logic bus_reset_global_enable;
    logic remote_wake_request_bit;
    logic boot_rom_shadow_bit;
    logic pullup_connect_bit;
    logic func_bus_reset_flag;
    logic suspend_request_flag;
    logic resume_request_flag;
    logic wake_flag;
    logic idle_mode_bit;
    logic codec_reset_ctl_bit;
    logic external_irq_enable;
    logic [2:0] usb_irq_mask_reg;
    logic [PORT_W-1:0] wake_mask;
    logic [7:0] vector;
    logic vec_wr;

    assign hard_rst = srst_in | ~mrst_n_sync;  // R01
    assign glob_rst = hard_rst | usb_glob_rst;  // R03
    assign vec_wr   = wr_in && addr_in == `ADDR_IRQ_VEC;

    // Global reset pulse one cycle after an enabled bus reset
    always_ff @(posedge clk_in) begin
        if (hard_rst) begin
            usb_glob_rst <= 1'b0;
        end else begin
            usb_glob_rst <= bus_reset_det_in & bus_reset_global_enable & ~usb_glob_rst;  // R03
        end
    end

    // Reset outputs registered
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            reset_out         <= 1'b1;
            core_reset_out    <= 1'b1;
            sie_ubm_reset_out <= 1'b1;
        end else begin
            reset_out      <= ~mrst_n_sync | (bus_reset_det_in & bus_reset_global_enable);  // R07
            core_reset_out <= ~mrst_n_sync | (bus_reset_det_in & bus_reset_global_enable);  // R01
            sie_ubm_reset_out <= ~mrst_n_sync | bus_reset_det_in;  // R05
        end
    end

    // ==========================================
    // Control bits kept through bus global reset
    always_ff @(posedge clk_in) begin
        if (hard_rst) begin
            bus_reset_global_enable <= 1'b0;
            boot_rom_shadow_bit     <= 1'b0;
            pullup_connect_bit      <= 1'b0;
        end else if (wr_in && addr_in == `ADDR_USB_CTL) begin
            bus_reset_global_enable <= wdata_in[`BIT_GLOB_EN];
            boot_rom_shadow_bit     <= wdata_in[`BIT_SHADOW];  // R03
            pullup_connect_bit      <= wdata_in[`BIT_CONNECT];
        end
    end

    // Ordinary control bits reset by any global reset
    always_ff @(posedge clk_in) begin
        if (glob_rst) begin
            remote_wake_request_bit <= 1'b0;
            usb_irq_mask_reg        <= 3'h0;
            external_irq_enable     <= 1'b0;
            wake_mask               <= PORT_W'(`WAKE_MSK_RST);
        end else if (wr_in) begin
            case (addr_in)
                `ADDR_USB_CTL: begin
                    remote_wake_request_bit <= wdata_in[`BIT_RWAKE];
                end
                `ADDR_USB_MSK: begin
                    usb_irq_mask_reg <= wdata_in[2:0];
                end
                `ADDR_GLOBAL_CTL: begin
                    external_irq_enable <= wdata_in[`BIT_XIRQ_EN];
                end
                `ADDR_WAKE_MSK: begin
                    wake_mask <= wdata_in[PORT_W-1:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Codec reset untouched by master and bus resets
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            codec_reset_ctl_bit <= 1'b0;
        end else if (wr_in && addr_in == `ADDR_CODEC_CTL) begin
            codec_reset_ctl_bit <= wdata_in[`BIT_CODEC_RST];  // R08
        end
    end
    assign codec_reset_n_out = codec_reset_ctl_bit;  // R08

    // ==========================================
    // Bus reset flag, set wins over vector clear
    always_ff @(posedge clk_in) begin
        if (glob_rst && !bus_reset_det_in) begin
            func_bus_reset_flag <= 1'b0;  // R06
        end else if (bus_reset_det_in) begin
            func_bus_reset_flag <= 1'b1;  // R02
        end else if (vec_wr && vector == `VEC_BUS_RST) begin
            func_bus_reset_flag <= 1'b0;  // R06
        end
    end

    // ==========================================
    // Idle detection
    logic [CNT_W-1:0] idle_cnt;
    logic             idle_hit;

    assign idle_hit = idle_sync && idle_cnt == IDLE_LAST;

    // Counts uninterrupted J, saturates past the limit
    always_ff @(posedge clk_in) begin
        if (glob_rst || !idle_sync) begin
            idle_cnt <= '0;  // R22
        end else if (idle_cnt <= IDLE_LAST) begin
            idle_cnt <= idle_cnt + 1'b1;
        end
    end

    // Suspend request flag
    always_ff @(posedge clk_in) begin
        if (glob_rst) begin
            suspend_request_flag <= 1'b0;
        end else if (idle_hit) begin
            suspend_request_flag <= 1'b1;  // R09
        end else if (vec_wr && vector == `VEC_SUSP) begin
            suspend_request_flag <= 1'b0;  // R12
        end
    end

    // ==========================================
    // Idle mode, resume and wake
    logic              resume_hit;
    logic              wake_gated;
    logic              wake_gated_d;
    logic              wake_hit;
    logic [PORT_W-1:0] port_eff;

    assign resume_hit = idle_mode_bit && !idle_sync;  // R13

    // Irq pin stands in for port bit 2 while suspended
    always_comb begin
        port_eff = port_sync;
        if (idle_mode_bit) begin
            port_eff[`WAKE_XIRQ_BIT] = xirq_sync;  // R18
        end
    end

    assign wake_gated = idle_mode_bit & (|(~port_eff & ~wake_mask));  // R19 R21
    assign wake_hit   = wake_gated & ~wake_gated_d;  // R19

    // Delayed gated level for edge detection
    always_ff @(posedge clk_in) begin
        if (glob_rst) begin
            wake_gated_d <= 1'b0;
        end else begin
            wake_gated_d <= wake_gated;
        end
    end

    // Idle bit: hardware wake clears win over software
    always_ff @(posedge clk_in) begin
        if (glob_rst || resume_hit || wake_hit) begin
            idle_mode_bit <= 1'b0;  // R13 R15
        end else if (wr_in && addr_in == `ADDR_PWR_CTL) begin
            idle_mode_bit <= wdata_in[`BIT_IDLE];  // R10
        end
    end
    assign clocks_run_out = ~idle_mode_bit;  // R10

    // Resume request flag
    always_ff @(posedge clk_in) begin
        if (glob_rst) begin
            resume_request_flag <= 1'b0;
        end else if (resume_hit) begin
            resume_request_flag <= 1'b1;  // R13
        end else if (vec_wr && vector == `VEC_RES) begin
            resume_request_flag <= 1'b0;  // R14
        end
    end

    // Wake flag
    always_ff @(posedge clk_in) begin
        if (glob_rst) begin
            wake_flag <= 1'b0;
        end else if (wake_hit) begin
            wake_flag <= 1'b1;  // R19
        end else if (vec_wr && vector == `VEC_WAKE) begin
            wake_flag <= 1'b0;
        end
    end

    // ==========================================
    // Remote wake K signaling
    logic [CNT_W-1:0] k_cnt;
    logic             rwake_d;

    // Extends K by the fixed time after the request falls
    always_ff @(posedge clk_in) begin
        if (glob_rst) begin
            k_cnt   <= '0;
            rwake_d <= 1'b0;
        end else begin
            rwake_d <= remote_wake_request_bit;
            if (rwake_d && !remote_wake_request_bit) begin
                k_cnt <= K_LOAD;  // R17
            end else if (k_cnt != '0) begin
                k_cnt <= k_cnt - 1'b1;
            end
        end
    end
    // Delayed request bridges the cycle before the counter loads
    assign drive_k_out = remote_wake_request_bit | rwake_d | (k_cnt != '0);  // R17

    // ==========================================
    // Interrupt vector and outputs
    irq_src_t src;
    logic     rst_irq;
    logic     wake_irq;

    assign rst_irq  = func_bus_reset_flag & usb_irq_mask_reg[`BIT_RST]
                      & ~bus_reset_global_enable;  // R04
    assign wake_irq = wake_flag & external_irq_enable;  // R20

    // Highest pending source
    always_comb begin
        if (rst_irq) begin
            src = SRC_RST;
        end else if (suspend_request_flag && usb_irq_mask_reg[`BIT_SUSP]) begin
            src = SRC_SUSP;
        end else if (resume_request_flag && usb_irq_mask_reg[`BIT_RES]) begin
            src = SRC_RES;
        end else if (wake_irq) begin
            src = SRC_WAKE;
        end else begin
            src = SRC_NONE;
        end
    end

    // Vector encoding
    always_comb begin
        case (src)
            SRC_RST:  vector = `VEC_BUS_RST;
            SRC_SUSP: vector = `VEC_SUSP;
            SRC_RES:  vector = `VEC_RES;
            SRC_WAKE: vector = `VEC_WAKE;  // R20
            default:  vector = `VEC_NONE;
        endcase
    end

    assign int0_out    = rst_irq | wake_irq;  // R04 R20
    assign usb_irq_out = src != SRC_NONE;
    assign pullup_connect_out  = pullup_connect_bit;
    assign boot_rom_shadow_out = boot_rom_shadow_bit;

    // ==========================================
    // Read data one cycle after strobe
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rdata_out <= 8'h00;
        end else if (rd_in) begin
            case (addr_in)
                `ADDR_USB_CTL: rdata_out <= {4'h0, pullup_connect_bit, boot_rom_shadow_bit,
                                             remote_wake_request_bit, bus_reset_global_enable};
                `ADDR_USB_STA: rdata_out <= {5'h00, resume_request_flag, suspend_request_flag,
                                             func_bus_reset_flag};
                `ADDR_USB_MSK: rdata_out <= {5'h00, usb_irq_mask_reg};
                `ADDR_IRQ_VEC: rdata_out <= vector;
                `ADDR_CODEC_CTL: rdata_out <= {7'h00, codec_reset_ctl_bit};
                `ADDR_PWR_CTL: rdata_out <= {7'h00, idle_mode_bit};
                `ADDR_GLOBAL_CTL: rdata_out <= {7'h00, external_irq_enable};
                `ADDR_WAKE_MSK: rdata_out <= 8'(wake_mask);
                default: rdata_out <= 8'h00;
            endcase
        end else begin
            rdata_out <= 8'h00;
        end
    end

    // ==========================================
    // Assertions
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (srst_in);

    sequence enabled_bus_reset;
        bus_reset_det_in && bus_reset_global_enable && !usb_glob_rst;
    endsequence

    sequence cleared_next;
        ##1 usb_glob_rst ##1 !func_bus_reset_flag;
    endsequence

    rst_flag_set_a: assert property (bus_reset_det_in |=> func_bus_reset_flag)  // R02
        else $error("bus reset flag not set");
    glob_rst_route_a: assert property (enabled_bus_reset |-> cleared_next)  // R03 R06
        else $error("global bus reset did not clear flag");
    rst_out_a: assert property (enabled_bus_reset |=> reset_out && core_reset_out)  // R07
        else $error("reset output missed bus reset");
    int0_route_a: assert property (bus_reset_det_in && !bus_reset_global_enable
        && usb_irq_mask_reg[`BIT_RST] |=> int0_out && !reset_out)  // R04
        else $error("bus reset interrupt missing");
    local_rst_a: assert property (bus_reset_det_in |=> sie_ubm_reset_out)  // R05
        else $error("engine reset missing");
    codec_follow_a: assert property (wr_in && addr_in == `ADDR_CODEC_CTL
        |=> codec_reset_n_out == $past(wdata_in[`BIT_CODEC_RST]))  // R08
        else $error("codec reset does not follow bit");
    susp_set_a: assert property (idle_hit && !glob_rst |=> suspend_request_flag)  // R09
        else $error("suspend flag not set after idle");
    susp_clr_a: assert property (vec_wr && vector == `VEC_SUSP && !idle_hit
        && !glob_rst |=> !suspend_request_flag)  // R12
        else $error("suspend flag not cleared");
    clk_stop_a: assert property (idle_mode_bit |-> !clocks_run_out)  // R10
        else $error("clocks run in idle");
    resume_a: assert property (resume_hit && !glob_rst
        |=> resume_request_flag && !idle_mode_bit && clocks_run_out)  // R13
        else $error("resume not handled");
    idle_restart_a: assert property (!idle_sync |=> idle_cnt == '0)  // R22
        else $error("idle counter not restarted");
    wake_end_a: assert property (wake_hit && !glob_rst |=> wake_flag && !idle_mode_bit)  // R19
        else $error("wake edge did not end suspend");
    wake_vec_a: assert property (wake_flag && !external_irq_enable |-> !wake_irq)  // R20
        else $error("wake interrupt without enable");
    k_drive_a: assert property (rwake_d && !remote_wake_request_bit && !glob_rst
        |-> drive_k_out [*8])  // R17
        else $error("k state ended early");

endmodule // usb_reset_suspend_wakeup

// ---- usb_rsw_consts.svh ----
// Constants for the USB reset, suspend and wake-up block
//
// Overview of operation
// R01 - Master reset pin resets all logic and the core, overriding everything; the code keeps the codec control bit.
// R02 - Every detected bus reset sets the bus reset flag.
// R03 - With global enable set, bus reset resets all except shadow and connect bits; the code also keeps the global enable bit.
// R04 - Global enable clear and mask set: bus reset raises external interrupt 0.
// R05 - Neither bit set: bus reset resets only serial engine and buffer manager.
// R06 - Bus reset flag cleared by its global reset or vector write at 0x17.
// R07 - Reset output active on master reset and on globally enabled bus reset.
// R08 - Codec reset follows only its control bit: 0 asserts, 1 releases.
// R09 - 5 ms of constant idle J sets suspend flag and raises interrupt.
// R10 - Idle mode bit, bit 0 of power control, stops all internal clocks.
// R11 - Firmware sets idle mode after suspend interrupt, never inside a service routine.
// R12 - Any write to vector register while vector is 0x16 clears suspend flag.
// R13 - Non-idle bus while suspended restarts clocks, sets resume flag, clears idle.
// R14 - Resume flag cleared by vector register write during resume service.
// R15 - Core continues after the instruction that set idle mode.
// R16 - Firmware pulses remote wake request 1 then 0 when permitted.
// R17 - Remote wake pulse drives K upstream for pulse width plus 1 to 2 ms.
// R18 - Falling edge on unmasked wake port bit wakes; irq pin acts as bit 2.
// R19 - Masked bits ORed, qualified by suspend; rising edge sets wake flag, ends suspend.
// R20 - Wake flag interrupts only when enabled, with vector 0x1F.
// R21 - External irq during suspend ignored when wake port bit 2 mask is set.
// R22 - Idle counter restarts on any non-idle bus state.
`ifndef USB_RSW_CONSTS_SVH
`define USB_RSW_CONSTS_SVH

// ==========================================
// Register offsets
`define ADDR_USB_CTL     3'h0
`define ADDR_USB_STA     3'h1
`define ADDR_USB_MSK     3'h2
`define ADDR_IRQ_VEC     3'h3
`define ADDR_CODEC_CTL   3'h4
`define ADDR_PWR_CTL     3'h5
`define ADDR_GLOBAL_CTL  3'h6
`define ADDR_WAKE_MSK    3'h7

// ==========================================
// Field positions
`define BIT_GLOB_EN      0
`define BIT_RWAKE        1
`define BIT_SHADOW       2
`define BIT_CONNECT      3
`define BIT_RST          0
`define BIT_SUSP         1
`define BIT_RES          2
`define BIT_CODEC_RST    0
`define BIT_IDLE         0
`define BIT_XIRQ_EN      0
`define WAKE_XIRQ_BIT    2

// ==========================================
// Vectors and reset values
`define VEC_NONE         8'h00
`define VEC_BUS_RST      8'h17
`define VEC_SUSP         8'h16
`define VEC_RES          8'h18
`define VEC_WAKE         8'h1f
`define WAKE_MSK_RST     8'hff

// ==========================================
// Timing
`define CLK_FREQ_KHZ     25000
`define IDLE_TIME_US     5000
`define K_EXT_TIME_US    1000

`endif

// ---- usb_rsw_pkg.sv ----
// Types for the USB reset, suspend and wake-up block
package usb_rsw_pkg;
    typedef enum {SRC_NONE, SRC_RST, SRC_SUSP, SRC_RES, SRC_WAKE} irq_src_t;
endpackage
